/* rtl/ifps_pkg.sv */
/*
 * ifps_pkg: constants shared by the interface pin-function block.
 * Assumes a 40 MHz mclk and byte addresses on the register bus.
 */
package ifps_pkg;

	// register byte offsets
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  REG_CFG       = 5'h00;
	localparam logic [4:0]  REG_WAVE      = 5'h04;
	localparam logic [4:0]  REG_TSEL      = 5'h08;
	localparam logic [4:0]  REG_STS       = 5'h0c;
	localparam logic [4:0]  REG_MSK       = 5'h10;
	localparam logic [4:0]  REG_PINS      = 5'h14;

	// interface_config_reg fields
	localparam int          CFG_MODE_LO   = 0;
	localparam int          CFG_INV_BIT   = 4;
	localparam int          CFG_AUX_BIT   = 5;
	localparam int          CFG_F48_BIT   = 6;
	localparam int          CFG_INT_BIT   = 7;
	localparam logic [1:0]  MODE_SLAVE    = 2'h3;

	// reset values
	localparam logic [7:0]  CFG_RST       = 8'h00;
	localparam logic [5:0]  WAVE_RST      = 6'h3f;
	localparam logic [2:0]  TSEL_RST      = 3'h0;
	localparam logic [4:0]  EV_RST        = 5'h00;
	localparam logic [5:0]  PINS_OUT_RST  = 6'h3f;

	// event bits in status and mask
	localparam int          N_EV          = 5;
	localparam int          EV_IRQ4       = 0;
	localparam int          EV_IRQ5       = 1;
	localparam int          EV_T0         = 2;

	// synchronised pin vector layout
	localparam int          N_PIN         = 9;
	localparam int          PIN_IRQ4      = 0;
	localparam int          PIN_IRQ5      = 1;
	localparam int          PIN_T0        = 2;
	localparam int          PIN_RX        = 5;
	localparam int          PIN_FSEL      = 6;
	localparam int          PIN_INTERFACE_CLOCK     = 8;
	// irq five and receive rest high: no false edge or start bit on release
	localparam logic [8:0]  PIN_RST       = 9'h022;

	// interface clock generation
	localparam int          MCLK_HZ       = 40_000_000;
	localparam int          INTERFACE_CLOCK_30_HZ   = 30_000_000;
	localparam int          INTERFACE_CLOCK_48_HZ   = 48_000_000;
	localparam int          DIV_W         = 8;
	localparam int          HALF_30_I     = MCLK_HZ / (2 * INTERFACE_CLOCK_30_HZ);
	localparam int          HALF_48_I     = MCLK_HZ / (2 * INTERFACE_CLOCK_48_HZ);
	localparam logic [7:0]  HALF_30       =
		(HALF_30_I < 1) ? 8'h01 : HALF_30_I[7:0];
	localparam logic [7:0]  HALF_48       =
		(HALF_48_I < 1) ? 8'h01 : HALF_48_I[7:0];

endpackage : ifps_pkg

/* rtl/ifps_sync_edge.sv */
/*
 * ifps_sync_edge: two-flop synchroniser with edge detect per bit.
 * Assumes inputs are asynchronous pins; outputs are mclk-domain.
 */
`timescale 1ns/1ps
module ifps_sync_edge #(
	parameter int             W       = 9,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	// raw pins
	input  wire logic [W-1:0]  pin_in,
	// synchronised view
	output logic      [W-1:0]  level,
	output logic      [W-1:0]  rise,
	output logic      [W-1:0]  fall
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
	} ifps_sync_s;

	ifps_sync_s s;
	ifps_sync_s next_s;

	// meta feeds only sync; edges look at sync and prev
	always_comb begin
		next_s = s;
		if (ce) begin
			next_s.meta = pin_in;
			next_s.sync = s.meta;
			next_s.prev = s.sync;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{meta: RST_VAL, sync: RST_VAL, prev: RST_VAL};
		end else begin
			s <= next_s;
		end
	end

	assign level = s.sync;
	assign rise  = s.sync & ~s.prev;
	assign fall  = ~s.sync & s.prev;

endmodule : ifps_sync_edge

/* rtl/ifps_pin_func.sv */
/*
 * ifps_pin_func: pin-function logic of the external interface pins,
 * with an Avalon-MM slave for configuration, status and interrupt.
 * Assumes pins are asynchronous to mclk and the fifo flag vectors come
 * from logic clocked by mclk.
 */
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
// What this block does
// - shared pins: control output or fifo flag
// - first shared pin: selected fifo level flag
// - second shared pin: selected fifo full flag
// - third shared pin: selected fifo empty flag
// - all control pins come up high
// - interface clock edge times flags and controls
// - internal source drives clock pin at mclk/2 for both 30/48 selects
// - invert bit inverts internal or external clock
// - irq four on rising input edge
// - irq five on falling input edge
// - timer two counts pin only when selected
// - timer one counts pin only when selected
// - timer zero counts pin only when selected
// - serial one receive pin always delivers data
module ifps_pin_func #(
	parameter int N_FIFO = 4
) (
	// clock, reset, enable
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        ce,
	// avalon-mm slave
	input  wire logic [ifps_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	// interrupt
	output logic                             irq,
	// fifo core flags, one bit per fifo
	input  wire logic [N_FIFO-1:0]           fifo_level_flag,
	input  wire logic [N_FIFO-1:0]           fifo_full_flag,
	input  wire logic [N_FIFO-1:0]           fifo_empty_flag,
	// input pins
	input  wire logic [1:0]                  fifo_select_pins,
	input  wire logic                        irq_four_rising,
	input  wire logic                        irq_five_falling_n,
	input  wire logic                        timer_zero_count_in,
	input  wire logic                        timer_one_count_in,
	input  wire logic                        timer_two_count_in,
	input  wire logic                        serial_one_receive_in,
	// interface clock pin
	input  wire logic                        interface_clock_in,
	output logic                             interface_clock_out,
	output logic                             interface_clock_oe,
	// shared control-or-flag pins
	output logic                             wave_control_out_zero,
	output logic                             wave_control_out_one,
	output logic                             wave_control_out_two,
	// dedicated control pins
	output logic                             wave_control_out_three,
	output logic                             wave_control_out_four,
	output logic                             wave_control_out_five,
	// core side
	output logic                             interface_clock_edge,
	output logic                             irq_four_pulse,
	output logic                             irq_five_pulse,
	output logic                             timer_zero_count_pulse,
	output logic                             timer_one_count_pulse,
	output logic                             timer_two_count_pulse,
	output logic                             serial_one_rx_data
);
	import ifps_pkg::*;

	typedef struct packed {
		logic [7:0]       cfg;
		logic [5:0]       wave;
		logic [2:0]       tsel;
		logic [N_EV-1:0]  sts;
		logic [N_EV-1:0]  msk;
		logic             ack;
		logic [31:0]      rdata;
		logic [DIV_W-1:0] div;
		logic             gen_clk;
		logic             clk_pin;
		logic             eff_prev;
		logic             if_edge;
		logic             sel_fifo;
		logic [5:0]       pins_out;
		logic [N_EV-1:0]  ev_pulse;
		logic             rx;
	} ifps_state_s;

	localparam ifps_state_s RST_STATE = '{
		cfg:      CFG_RST,
		wave:     WAVE_RST,
		tsel:     TSEL_RST,
		sts:      EV_RST,
		msk:      EV_RST,
		ack:      1'b0,
		rdata:    32'h0000_0000,
		div:      8'h00,
		gen_clk:  1'b0,
		clk_pin:  1'b0,
		eff_prev: 1'b0,
		if_edge:  1'b0,
		sel_fifo: 1'b0,
		pins_out: PINS_OUT_RST,
		ev_pulse: EV_RST,
		rx:       1'b1
	};

	ifps_state_s s;
	ifps_state_s next_s;

	// synchronised pins
	logic [N_PIN-1:0] pin_raw;
	logic [N_PIN-1:0] pin_lvl;
	logic [N_PIN-1:0] pin_rise;
	logic [N_PIN-1:0] pin_fall;

	// placed by the package layout, so the pins readback agrees with it
	assign pin_raw[PIN_IRQ4]      = irq_four_rising;
	assign pin_raw[PIN_IRQ5]      = irq_five_falling_n;
	assign pin_raw[PIN_T0]        = timer_zero_count_in;
	assign pin_raw[PIN_T0 + 1]    = timer_one_count_in;
	assign pin_raw[PIN_T0 + 2]    = timer_two_count_in;
	assign pin_raw[PIN_RX]        = serial_one_receive_in;
	assign pin_raw[PIN_FSEL +: 2] = fifo_select_pins;
	assign pin_raw[PIN_INTERFACE_CLOCK]     = interface_clock_in;

	ifps_sync_edge #(
		.W       (N_PIN),
		.RST_VAL (PIN_RST)
	) u_sync (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.ce     (ce),
		.pin_in (pin_raw),
		.level  (pin_lvl),
		.rise   (pin_rise),
		.fall   (pin_fall)
	);

	// pin events
	logic [N_EV-1:0] ev_now;
	logic [2:0]      tcnt_ev;

	assign ev_now[EV_IRQ4] = pin_rise[PIN_IRQ4];
	assign ev_now[EV_IRQ5] = pin_fall[PIN_IRQ5];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_tmr
			// deselected timers ignore the pin entirely
			assign tcnt_ev[gi] = pin_rise[PIN_T0 + gi] & s.tsel[gi];
		end
	endgenerate
	assign ev_now[EV_T0 +: 3] = tcnt_ev;

	// flags of the fifo addressed by the select pins
	logic [1:0] fsel;
	logic [2:0] flag_sel;
	logic [5:0] ctl_next;

	assign fsel        = pin_lvl[PIN_FSEL +: 2];
	assign flag_sel[0] = fifo_level_flag[fsel];
	assign flag_sel[1] = fifo_full_flag[fsel];
	assign flag_sel[2] = fifo_empty_flag[fsel];

	generate
		for (gi = 0; gi < 6; gi++) begin : g_pin
			if (gi < 3) begin : g_shared
				assign ctl_next[gi] = s.sel_fifo ? flag_sel[gi]
					: s.wave[gi];
			end else begin : g_ded
				assign ctl_next[gi] = s.wave[gi];
			end
		end
	endgenerate

	// effective interface clock and its rising edge
	logic       int_clk;
	logic       inv_clk;
	logic       eff_now;
	logic       if_rise;
	logic [7:0] half_cnt;

	assign int_clk  = s.cfg[CFG_INT_BIT];
	assign inv_clk  = s.cfg[CFG_INV_BIT];
	assign half_cnt = s.cfg[CFG_F48_BIT] ? HALF_48 : HALF_30;
	assign eff_now  = (int_clk ? s.gen_clk : pin_lvl[PIN_INTERFACE_CLOCK])
		^ inv_clk;
	assign if_rise  = eff_now & ~s.eff_prev;

	// bus decode
	logic        req;
	logic        take;
	logic        wr_lo;
	logic [31:0] rd_mux;
	logic [4:0]  reg_addr;

	// registers sit on word addresses; the low two bits are ignored
	assign reg_addr = {avs_address[4:2], 2'b00};
	assign req   = avs_read | avs_write;
	assign take  = req & s.ack;
	assign wr_lo = avs_write & take & avs_byteenable[0];

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_addr)
			REG_CFG:  rd_mux[7:0]        = s.cfg;
			REG_WAVE: rd_mux[5:0]        = s.wave;
			REG_TSEL: rd_mux[2:0]        = s.tsel;
			REG_STS:  rd_mux[N_EV-1:0]   = s.sts;
			REG_MSK:  rd_mux[N_EV-1:0]   = s.msk;
			REG_PINS: rd_mux[N_PIN-1:0]  = pin_lvl;
			default:  rd_mux             = 32'h0000_0000;
		endcase
	end

	always_comb begin
		next_s = s;
		if (ce) begin
			// one wait cycle, then the request is taken
			next_s.ack = req & ~s.ack;
			if (avs_read & ~s.ack) begin
				next_s.rdata = rd_mux;
			end

			// register writes
			if (wr_lo) begin
				case (reg_addr)
					REG_CFG:  next_s.cfg  = avs_writedata[7:0];
					REG_WAVE: next_s.wave = avs_writedata[5:0];
					REG_TSEL: next_s.tsel = avs_writedata[2:0];
					REG_MSK:  next_s.msk  = avs_writedata[N_EV-1:0];
					default:  next_s.cfg  = s.cfg;
				endcase
			end

			// sticky status: a new event beats a same-cycle clear
			next_s.sts = s.sts;
			if (wr_lo && (reg_addr == REG_STS)) begin
				next_s.sts = s.sts & ~avs_writedata[N_EV-1:0];
			end
			next_s.sts = next_s.sts | ev_now;

			// core-side pulses and receive data
			next_s.ev_pulse = ev_now;
			next_s.rx       = pin_lvl[PIN_RX];

			// internal interface clock divider; from a 40 MHz mclk both
			// selections floor below one and clamp to one cycle a half, so the pin runs mclk/2
			if (int_clk) begin
				if (s.div == 8'h00) begin
					next_s.div     = 8'(half_cnt - 8'h01);
					next_s.gen_clk = ~s.gen_clk;
				end else begin
					next_s.div = 8'(s.div - 8'h01);
				end
			end else begin
				next_s.div     = 8'h00;
				next_s.gen_clk = 1'b0;
			end
			// pin copy registered, so an invert write cannot glitch it
			next_s.clk_pin = next_s.gen_clk
				^ next_s.cfg[CFG_INV_BIT];

			// pin outputs move only on the interface clock edge
			next_s.eff_prev = eff_now;
			next_s.if_edge  = if_rise;
			if (if_rise) begin
				next_s.pins_out = ctl_next;
				// selection lands here so a switch never glitches mid-cycle
				next_s.sel_fifo = (s.cfg[CFG_MODE_LO +: 2]
					== MODE_SLAVE);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s <= RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	// bus answers
	assign avs_waitrequest = req & ~s.ack;
	assign avs_readdata    = s.rdata;
	assign irq             = |(s.sts & s.msk);

	// interface clock pin
	assign interface_clock_out = s.clk_pin;
	assign interface_clock_oe  = int_clk;

	// control and flag pins
	assign wave_control_out_zero  = s.pins_out[0];
	assign wave_control_out_one   = s.pins_out[1];
	assign wave_control_out_two   = s.pins_out[2];
	assign wave_control_out_three = s.pins_out[3];
	assign wave_control_out_four  = s.pins_out[4];
	assign wave_control_out_five  = s.pins_out[5];

	// core side
	assign interface_clock_edge   = s.if_edge;
	assign irq_four_pulse         = s.ev_pulse[EV_IRQ4];
	assign irq_five_pulse         = s.ev_pulse[EV_IRQ5];
	assign timer_zero_count_pulse = s.ev_pulse[EV_T0];
	assign timer_one_count_pulse  = s.ev_pulse[EV_T0 + 1];
	assign timer_two_count_pulse  = s.ev_pulse[EV_T0 + 2];
	assign serial_one_rx_data     = s.rx;

endmodule : ifps_pin_func

/* test/ifps_pin_func_checker.sv */
/* checker: port-level timing of ifps_pin_func, bound to it.
   assumes ce is held high. */
`timescale 1ns/1ps
module ifps_pin_func_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// pins in
	input wire logic irq_four_rising,
	input wire logic irq_five_falling_n,
	input wire logic timer_zero_count_in,
	input wire logic serial_one_receive_in,
	// pins out
	input wire logic interface_clock_out,
	input wire logic interface_clock_oe,
	input wire logic wave_control_out_zero,
	input wire logic wave_control_out_one,
	input wire logic wave_control_out_two,
	input wire logic wave_control_out_three,
	input wire logic wave_control_out_four,
	input wire logic wave_control_out_five,
	// core side
	input wire logic interface_clock_edge,
	input wire logic irq_four_pulse,
	input wire logic irq_five_pulse,
	input wire logic timer_zero_count_pulse,
	input wire logic serial_one_rx_data
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	logic [5:0] pins;
	assign pins = {wave_control_out_five, wave_control_out_four,
		wave_control_out_three, wave_control_out_two,
		wave_control_out_one, wave_control_out_zero};
	rst_high_a: assert property (!$past(rst_n) |-> &pins)
		else $error("control pins not high after reset");
	pins_hold_a: assert property (
		!interface_clock_edge |-> $stable(pins))
		else $error("pins moved without interface clock edge");
	edge_single_a: assert property (
		interface_clock_edge |=> !interface_clock_edge)
		else $error("interface clock edge pulse too long");
	clk_edge_a: assert property (
		interface_clock_oe && $rose(interface_clock_out)
		|-> ##[0:3] interface_clock_edge)
		else $error("driven clock rise gave no edge pulse");
	rise_event_a: assert property (
		$rose(irq_four_rising) |-> ##[2:4] irq_four_pulse)
		else $error("irq four rise missed");
	rise_cause_a: assert property (
		irq_four_pulse |-> $past(irq_four_rising, 2))
		else $error("irq four pulse without rise");
	fall_event_a: assert property (
		$fell(irq_five_falling_n) |-> ##[2:4] irq_five_pulse)
		else $error("irq five fall missed");
	count_cause_a: assert property (
		timer_zero_count_pulse |-> $past(timer_zero_count_in, 2))
		else $error("timer zero pulse without pin rise");
	rx_follow_a: assert property (
		$stable(serial_one_receive_in)[*6]
		|-> serial_one_rx_data == serial_one_receive_in)
		else $error("receive data does not follow pin");
endmodule : ifps_pin_func_checker

bind ifps_pin_func ifps_pin_func_checker ifps_pin_func_checker_inst (
	.mclk(mclk), .rst_n(rst_n), .irq_four_rising(irq_four_rising),
	.irq_five_falling_n(irq_five_falling_n),
	.timer_zero_count_in(timer_zero_count_in),
	.serial_one_receive_in(serial_one_receive_in),
	.interface_clock_out(interface_clock_out),
	.interface_clock_oe(interface_clock_oe),
	.wave_control_out_zero(wave_control_out_zero),
	.wave_control_out_one(wave_control_out_one),
	.wave_control_out_two(wave_control_out_two),
	.wave_control_out_three(wave_control_out_three),
	.wave_control_out_four(wave_control_out_four),
	.wave_control_out_five(wave_control_out_five),
	.interface_clock_edge(interface_clock_edge),
	.irq_four_pulse(irq_four_pulse), .irq_five_pulse(irq_five_pulse),
	.timer_zero_count_pulse(timer_zero_count_pulse),
	.serial_one_rx_data(serial_one_rx_data)
);

/* test/ifps_fifo_master.sv */
/* fifo master model: makes the interface clock, drives fifo select.
   assumes run changes on mclk edges. */
`timescale 1ns/1ps
module ifps_fifo_master (
	// from bench
	input  wire logic       run,
	input  wire logic [1:0] sel,
	// toward device
	output logic            interface_clock,
	output logic [1:0]      fsel
);
	// one process owns both outputs; select moves while the clock is
	// low, clear of the rising edge that the device samples on
	initial begin
		interface_clock = 1'b0;
		fsel  = 2'h0;
		forever begin
			#100;
			interface_clock = run ? !interface_clock : 1'b0;
			if (!interface_clock) begin
				fsel = sel;
			end
		end
	end
endmodule : ifps_fifo_master

/* test/ifps_pin_func_tb_top.sv */
/* bench: drives ifps_pin_func, compares with an integer model.
   assumes the fifo master model and the bound checker. */
`timescale 1ns/1ps
module ifps_pin_func_tb_top;
	import ifps_pkg::*;
	logic        mclk, rst_n, rd, wr, run, irq, oe, ck, edg, mck, ifck;
	logic        rxp, rxd, wrq;
	logic [4:0]  adr, evp, pul;
	logic [31:0] wd, rdo, got, rnd;
	logic [3:0]  lvl, ful, emp;
	logic [1:0]  sel, fsel;
	logic [5:0]  pins;
	logic [4:0]  ra[7] = '{REG_CFG, REG_WAVE, REG_TSEL, REG_STS, REG_MSK,
		5'h18, REG_PINS};
	// pins readback: receive and irq five idle high, the rest low
	int          rv[7] = '{0, 'h3f, 0, 0, 0, 0, 'h22};
	int          bad_count, num_checks, cyc, n, i, p, pcnt;
	int          cfg, wave, tsel, sts;
	assign ifck = oe ? ck : mck;
	ifps_pin_func ifps_pin_func_inst (
		.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(4'h1), .avs_readdata(rdo), .avs_waitrequest(wrq),
		.irq(irq), .fifo_level_flag(lvl), .fifo_full_flag(ful),
		.fifo_empty_flag(emp), .fifo_select_pins(fsel),
		.irq_four_rising(evp[0]), .irq_five_falling_n(evp[1]),
		.timer_zero_count_in(evp[2]), .timer_one_count_in(evp[3]),
		.timer_two_count_in(evp[4]), .serial_one_receive_in(rxp),
		.interface_clock_in(ifck), .interface_clock_out(ck),
		.interface_clock_oe(oe), .wave_control_out_zero(pins[0]),
		.wave_control_out_one(pins[1]), .wave_control_out_two(pins[2]),
		.wave_control_out_three(pins[3]), .wave_control_out_four(pins[4]),
		.wave_control_out_five(pins[5]), .interface_clock_edge(edg),
		.irq_four_pulse(pul[0]), .irq_five_pulse(pul[1]),
		.timer_zero_count_pulse(pul[2]), .timer_one_count_pulse(pul[3]),
		.timer_two_count_pulse(pul[4]), .serial_one_rx_data(rxd)
	);
	ifps_fifo_master ifps_fifo_master_inst (
		.run(run), .sel(sel), .interface_clock(mck), .fsel(fsel)
	);
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	task automatic complete_run();
		if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// waitrequest and read data are taken at the rising edge, before
	// the design's updates of that edge land
	task automatic bus(input logic w, input logic [4:0] a, input int d);
		@(posedge mclk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge mclk);
			n = wrq;
			got = rdo;
		end while (n);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic put(input logic [4:0] a, input int d);
		bus(1'b1, a, d);
		case (a)
			REG_CFG: cfg = d & 'hff;
			REG_WAVE: wave = d & 'h3f;
			REG_TSEL: tsel = d & 7;
			REG_STS: sts &= ~d;
			default: ;
		endcase
	endtask : put
	task automatic pchk();
		logic [5:0] e;
		repeat (3) @(posedge edg);
		// edge lands mid-phase: clock high unless inverted
		chk("phase", !cfg[CFG_INV_BIT], mck);
		@(negedge mclk);
		e = wave[5:0];
		if (cfg[1:0] == MODE_SLAVE) e[2:0] = {emp[sel], ful[sel], lvl[sel]};
		chk("pins", e, pins);
	endtask : pchk
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = !mclk;
	end
	always @(posedge mclk) begin
		pcnt += $countones(pul);
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		{rst_n, rd, wr, run, adr, wd, sel, lvl, ful, emp} = '0;
		evp = 5'h02;
		rxp = 1'b1;
		rnd = 32'd89336;
		wave = 'h3f;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		chk("pins", 'h3f, pins);
		chk("oe", 0, oe);
		put(5'h18, 'hff);
		for (i = 0; i < 7; i++) begin
			bus(1'b0, ra[i], 0);
			chk("reg", rv[i], got);
		end
		rnd = xs(rnd);
		put(REG_WAVE, int'(rnd[5:0]));
		repeat (20) @(posedge mclk);
		@(negedge mclk);
		chk("pins", 'h3f, pins);
		run <= 1'b1;
		pchk();
		put(REG_CFG, MODE_SLAVE);
		for (i = 0; i < 5; i++) begin
			rnd = xs(rnd);
			@(posedge mclk);
			{lvl, ful, emp} <= rnd[11:0];
			sel <= i[1:0];
			pchk();
		end
		put(REG_CFG, 'h13);
		pchk();
		run <= 1'b0;
		for (i = 0; i < 3; i++) begin
			put(REG_CFG, i == 0 ? 'h80 : (i == 1 ? 'h90 : 'hc0));
			repeat (4) @(posedge mclk);
			n = 0;
			repeat (40) begin
				@(negedge mclk);
				n += edg;
			end
			chk("edges", 40 / (2 * (i == 2 ? HALF_48 : HALF_30)), n);
			chk("oe", 1, oe);
		end
		put(REG_CFG, 0);
		@(negedge mclk);
		chk("oe", 0, oe);
		put(REG_MSK, 'h1f);
		for (p = 0; p < 2; p++) begin
			put(REG_TSEL, p * 7);
			for (i = 0; i < 5; i++) begin
				evp[i] <= !evp[i];
				repeat (6) @(posedge mclk);
				evp[i] <= !evp[i];
				repeat (6) @(posedge mclk);
				if (i < 2 || tsel[i - 2]) sts |= 1 << i;
			end
			bus(1'b0, REG_STS, 0);
			chk("status", sts, got);
			chk("irq", 1, irq);
			put(REG_MSK, 0);
			@(negedge mclk);
			chk("irq", 0, irq);
			put(REG_MSK, 'h1f);
			put(REG_STS, 'h1f);
			@(negedge mclk);
			chk("irq", 0, irq);
		end
		chk("pulses", 7, pcnt);
		for (i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			rxp <= rnd[0];
			repeat (5) @(posedge mclk);
			@(negedge mclk);
			chk("rx", rnd[0], rxd);
		end
		complete_run();
	end
endmodule : ifps_pin_func_tb_top
